// [design/psrc_pkg.sv]
// Purpose: Shared constants and carriers for the port drive and stop
//          recovery configuration block.
// Assumes: APB slave with 32-bit data, 8-bit byte address.
// Notes:   Register index times four gives the byte address.
package psrc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register indices (byte address = index * 4)
    localparam logic [5:0] PSRC_IDX_PORT_CFG   = 6'h00;
    localparam logic [5:0] PSRC_IDX_IRQ_STATUS = 6'h01;
    localparam logic [5:0] PSRC_IDX_IRQ_MASK   = 6'h02;
    localparam logic [5:0] PSRC_IDX_STOP_CTRL  = 6'h0B;

    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] PSRC_PORT_CFG_RST  = 8'hFE;
    localparam logic [7:0] PSRC_STOP_CTRL_RST = 8'h20;
    localparam logic [7:0] PSRC_IRQ_MASK_RST  = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Interrupt status bit positions
    localparam int PSRC_IRQ_RECOVERED = 0;
    localparam int PSRC_IRQ_WAKE      = 1;

    ////////////////////////////////////////////////////////////////////
    // Wake source encodings
    localparam logic [2:0] PSRC_SRC_RESET_ONLY = 3'h0;
    localparam logic [2:0] PSRC_SRC_P3_LINE0   = 3'h1;
    localparam logic [2:0] PSRC_SRC_P3_LINE1   = 3'h2;
    localparam logic [2:0] PSRC_SRC_P3_LINE2   = 3'h3;
    localparam logic [2:0] PSRC_SRC_P3_LINE3   = 3'h4;
    localparam logic [2:0] PSRC_SRC_P2_LINE7   = 3'h5;
    localparam logic [2:0] PSRC_SRC_P2_NOR4    = 3'h6;
    localparam logic [2:0] PSRC_SRC_P2_NOR8    = 3'h7;

    ////////////////////////////////////////////////////////////////////
    // Timing
    localparam int         PSRC_CLK_NS         = 4;
    localparam int         PSRC_STOP_DELAY_NS  = 4000;
    localparam int         PSRC_STOP_DELAY_CYC =
        PSRC_STOP_DELAY_NS / PSRC_CLK_NS;
    localparam logic [3:0] PSRC_DIV16_LAST     = 4'hF;

    ////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        PSRC_RUN,
        PSRC_STOPPED,
        PSRC_DELAY
    } psrc_mode_e;

    typedef struct packed {
        logic       osc_standard;
        logic [3:0] port_standard;
        logic       port0_push_pull;
        logic       port1_push_pull;
        logic       comp_route;
    } psrc_port_cfg_s;

    typedef struct packed {
        logic       stop_flag;
        logic       wake_level;
        logic       delay_en;
        logic [2:0] source;
        logic       full_speed;
        logic       div16;
    } psrc_stop_ctrl_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } psrc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } psrc_apb_rsp_s;

endpackage

// [design/psrc_wake_select.sv]
// Purpose: Picks the stop wake source and compares it to the wake level.
// Assumes: Pin inputs are already synchronised to the core clock.
// Notes:   Pure combinational logic.
`timescale 1ns/1ps
`default_nettype none
module psrc_wake_select
    import psrc_pkg::*;
(
    // Selection
    input  wire logic [2:0] source,
    input  wire logic       wake_level,
    // Synchronised pins
    input  wire logic [3:0] port3_in,
    input  wire logic [7:0] port2_in,
    // Result
    output logic            wake_match
);

    ////////////////////////////////////////////////////////////////////
    // Source multiplexer and level compare
    logic raw;

    always_comb begin
        raw        = 1'b0;
        wake_match = 1'b0;
        case (source)
            PSRC_SRC_P3_LINE0: raw = port3_in[0];
            PSRC_SRC_P3_LINE1: raw = port3_in[1];
            PSRC_SRC_P3_LINE2: raw = port3_in[2];
            PSRC_SRC_P3_LINE3: raw = port3_in[3];
            PSRC_SRC_P2_LINE7: raw = port2_in[7];
            PSRC_SRC_P2_NOR4:  raw = ~|port2_in[3:0];
            PSRC_SRC_P2_NOR8:  raw = ~|port2_in;
            default:           raw = 1'b0;
        endcase
        // Reset-only source never wakes from a pin
        if (source != PSRC_SRC_RESET_ONLY) begin
            wake_match = (raw == wake_level);
        end
    end

endmodule
`default_nettype wire

// [design/psrc_top.sv]
// Purpose: Port drive configuration and stop recovery control registers,
//          with wake detection, reset delay and core clock tick division.
// Assumes: APB master on clk; pins and comparators are asynchronous.
// Notes:   Only resetn (power-on) restores register defaults.
//
// Behaviour
// - Config bit 0 routes both comparator outputs to port 3 lines 4, 7.
// - Config bit 1 selects port 1 open-drain (0) or push-pull (1).
// - Config bit 2 selects port 0 open-drain (0) or push-pull (1).
// - Config bits 3 to 6 select reduced or standard drive, ports 0-3.
// - Config bit 7 selects oscillator drive; clock ratio stays unchanged.
// - Stop control bits 6:0 are write-only; bit 7 is read-only.
// - Stop flag set on stop recovery, cleared only by power-on reset.
// - Stop control bit 6 sets the wake level, default low.
// - Stop control bit 5 enables the reset delay after wake, default on.
// - Stop control bits 4:2 select the wake source, default reset only.
// - Stop control bit 1 selects crystal/2 (0) or crystal rate (1).
// - Stop control bit 0 adds divide-by-16 of core and timer clocks.
// - Stop control register decodes at index 0B.
// - Stop recovery keeps stop control bits 6:0 unchanged.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module psrc_top
    import psrc_pkg::*;
#(
    parameter int STOP_DELAY_CYCLES = PSRC_STOP_DELAY_CYC
)
(
    // Clock and power-on reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // APB slave
    input  wire psrc_pkg::psrc_apb_req_s  apb_req,
    output psrc_pkg::psrc_apb_rsp_s       apb_rsp,
    // Interrupt
    output logic                          irq,
    // Core stop handshake
    input  wire logic                     stop_enter,
    output logic                          in_stop,
    output logic                          stop_recovery_reset,
    // Divided clock ticks
    output logic                          core_tick,
    output logic                          timer_clock,
    // Asynchronous pins
    input  wire logic [3:0]               port3_in,
    input  wire logic [7:0]               port2_in,
    input  wire logic [1:0]               comparator_in,
    // Port 3 output lines
    input  wire logic                     port3_line4_data,
    input  wire logic                     port3_line7_data,
    output logic                          port3_line4,
    output logic                          port3_line7,
    // Drive selection to pad ring
    output psrc_pkg::psrc_port_cfg_s      drive_cfg
);

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        psrc_port_cfg_s  pcfg;
        psrc_stop_ctrl_s sctl;
        logic [7:0]      irq_status;
        logic [7:0]      irq_mask;
        logic [31:0]     prdata;
        logic            ack;
        logic            slverr;
        logic [1:0]      comp_s1;
        logic [1:0]      comp_s2;
        logic [11:0]     pin_s1;
        logic [11:0]     pin_s2;
        psrc_mode_e      mode;
        logic [15:0]     delay_cnt;
        logic            half;
        logic [3:0]      div_cnt;
        logic            tick;
        logic            recover;
        logic            line4;
        logic            line7;
    } psrc_state_s;

    psrc_state_s s;
    psrc_state_s next_s;

    logic [15:0] delay_last;
    logic        wake_match;

    assign delay_last = 16'(STOP_DELAY_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // Address helpers
    function automatic logic [5:0] word_index(input logic [7:0] addr);
        word_index = addr[7:2];
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == PSRC_IDX_PORT_CFG)  ||
                    (idx == PSRC_IDX_IRQ_STATUS) ||
                    (idx == PSRC_IDX_IRQ_MASK)  ||
                    (idx == PSRC_IDX_STOP_CTRL);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Wake source selection on synchronised pins
    psrc_wake_select u_wake (
        .source     (s.sctl.source),
        .wake_level (s.sctl.wake_level),
        .port3_in   (s.pin_s2[11:8]),
        .port2_in   (s.pin_s2[7:0]),
        .wake_match (wake_match)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [5:0] idx;
        logic       access;
        logic       complete;
        logic       clear_status;
        logic [7:0] events;
        logic       base_tick;

        idx          = word_index(apb_req.paddr);
        access       = apb_req.psel & apb_req.penable;
        complete     = access & s.ack;
        clear_status = 1'b0;
        events       = 8'h00;
        base_tick    = 1'b0;
        next_s       = s;

        // Two-flop synchronisers for pins and comparators
        next_s.comp_s1 = comparator_in;
        next_s.comp_s2 = s.comp_s1;
        next_s.pin_s1  = {port3_in, port2_in};
        next_s.pin_s2  = s.pin_s1;

        next_s.tick    = 1'b0;
        next_s.recover = 1'b0;

        // Clock tick divider, held cleared while stopped or stopping
        if ((s.mode == PSRC_RUN) && !stop_enter) begin
            next_s.half = ~s.half;
            base_tick   = s.sctl.full_speed | s.half;
            if (base_tick) begin
                if (s.sctl.div16) begin
                    next_s.div_cnt = s.div_cnt + 4'h1;
                    next_s.tick    = (s.div_cnt == PSRC_DIV16_LAST);
                end else begin
                    next_s.div_cnt = 4'h0;
                    next_s.tick    = 1'b1;
                end
            end
        end else begin
            next_s.half    = 1'b0;
            next_s.div_cnt = 4'h0;
        end

        // Stop and recovery sequence; only the stop flag and status events change
        case (s.mode)
            PSRC_RUN: begin
                if (stop_enter) begin
                    next_s.mode = PSRC_STOPPED;
                end
            end
            PSRC_STOPPED: begin
                if (wake_match) begin
                    events[PSRC_IRQ_WAKE] = 1'b1;
                    if (s.sctl.delay_en) begin
                        next_s.mode      = PSRC_DELAY;
                        next_s.delay_cnt = 16'h0000;
                    end else begin
                        next_s.mode           = PSRC_RUN;
                        next_s.recover        = 1'b1;
                        next_s.sctl.stop_flag = 1'b1;
                        events[PSRC_IRQ_RECOVERED] = 1'b1;
                    end
                end
            end
            PSRC_DELAY: begin
                next_s.delay_cnt = s.delay_cnt + 16'h0001;
                if (s.delay_cnt == delay_last) begin
                    next_s.mode           = PSRC_RUN;
                    next_s.recover        = 1'b1;
                    next_s.sctl.stop_flag = 1'b1;
                    events[PSRC_IRQ_RECOVERED] = 1'b1;
                end
            end
            default: begin
                next_s.mode = PSRC_RUN;
            end
        endcase

        // Comparator routing onto port 3 lines 4 and 7
        if (s.pcfg.comp_route) begin
            next_s.line4 = s.comp_s2[0];
            next_s.line7 = s.comp_s2[1];
        end else begin
            next_s.line4 = port3_line4_data;
            next_s.line7 = port3_line7_data;
        end

        // APB: first access cycle loads answer, second completes
        next_s.ack = access & ~s.ack;
        if (access & ~s.ack) begin
            next_s.slverr = ~is_mapped(idx);
            case (idx)
                PSRC_IDX_STOP_CTRL: begin
                    // Only the flag reads back
                    next_s.prdata = {24'h000000,
                                     s.sctl.stop_flag,
                                     7'h00};
                end
                PSRC_IDX_IRQ_STATUS: begin
                    next_s.prdata = {24'h000000, s.irq_status};
                end
                PSRC_IDX_IRQ_MASK: begin
                    next_s.prdata = {24'h000000, s.irq_mask};
                end
                // Port config reads as zero
                default: begin
                    next_s.prdata = 32'h00000000;
                end
            endcase
        end

        // Register writes at the completing edge
        if (complete & apb_req.pwrite & ~s.slverr) begin
            case (idx)
                PSRC_IDX_PORT_CFG: begin
                    next_s.pcfg = apb_req.pwdata[7:0];
                end
                PSRC_IDX_STOP_CTRL: begin
                    // Flag bit is not writable
                    next_s.sctl.wake_level = apb_req.pwdata[6];
                    next_s.sctl.delay_en   = apb_req.pwdata[5];
                    next_s.sctl.source     = apb_req.pwdata[4:2];
                    next_s.sctl.full_speed = apb_req.pwdata[1];
                    next_s.sctl.div16      = apb_req.pwdata[0];
                end
                PSRC_IDX_IRQ_MASK: begin
                    next_s.irq_mask = apb_req.pwdata[7:0];
                end
                default: begin
                    next_s.irq_mask = s.irq_mask;
                end
            endcase
        end

        // Status read clears; a new event in the same cycle survives
        if (complete & ~apb_req.pwrite & ~s.slverr &
            (idx == PSRC_IDX_IRQ_STATUS)) begin
            clear_status = 1'b1;
        end
        next_s.irq_status = (clear_status ? 8'h00 : s.irq_status) |
                            events;
    end

    ////////////////////////////////////////////////////////////////////
    // State register; power-on loads defaults
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s          <= '0;
            s.pcfg     <= PSRC_PORT_CFG_RST;
            s.sctl     <= PSRC_STOP_CTRL_RST;
            s.irq_mask <= PSRC_IRQ_MASK_RST;
            s.mode     <= PSRC_RUN;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign apb_rsp.pready      = s.ack;
    assign apb_rsp.prdata      = s.prdata;
    assign apb_rsp.pslverr     = s.ack & s.slverr;
    assign irq                 = |(s.irq_status & s.irq_mask);
    assign in_stop             = (s.mode != PSRC_RUN);
    assign stop_recovery_reset = s.recover;
    assign core_tick           = s.tick;
    assign timer_clock         = s.tick;
    assign port3_line4         = s.line4;
    assign port3_line7         = s.line7;
    // Oscillator drive bit has no effect on the tick ratio
    assign drive_cfg           = s.pcfg;

endmodule
`default_nettype wire

// [sim/psrc_props.sv]
// Purpose: Port-level checks of psrc_top.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to psrc_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module psrc_props
    import psrc_pkg::*;
#(
    parameter int STOP_DELAY_CYCLES = 4
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // APB
    input  wire psrc_pkg::psrc_apb_req_s  apb_req,
    input  wire psrc_pkg::psrc_apb_rsp_s  apb_rsp,
    // Stop and ticks
    input  wire logic                     in_stop,
    input  wire logic                     stop_enter,
    input  wire logic                     stop_recovery_reset,
    input  wire logic                     core_tick,
    input  wire logic                     timer_clock,
    // Port 3 lines and drive
    input  wire logic [1:0]               comparator_in,
    input  wire logic                     port3_line4_data,
    input  wire logic                     port3_line7_data,
    input  wire logic                     port3_line4,
    input  wire logic                     port3_line7,
    input  wire psrc_pkg::psrc_port_cfg_s drive_cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Decoded register map
    logic [5:0] idx;
    logic       mapped;
    assign idx    = apb_req.paddr[7:2];
    assign mapped = idx inside {PSRC_IDX_PORT_CFG, PSRC_IDX_IRQ_STATUS,
                                PSRC_IDX_IRQ_MASK, PSRC_IDX_STOP_CTRL};

    ////////////////////////////////////////////////////////////////////
    // Assertions
    a_ticks_paired: assert property (core_tick == timer_clock)
        else $error("core and timer ticks differ");
    a_no_tick_stop: assert property (in_stop |-> !core_tick)
        else $error("tick while stopped");
    a_pready_wait: assert property (apb_req.psel && $rose(apb_req.penable)
        |=> apb_rsp.pready)
        else $error("pready not one wait state");
    a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_slverr_map: assert property (apb_rsp.pready |->
        apb_rsp.pslverr == !mapped)
        else $error("error response wrong for index");
    a_stop_taken: assert property (stop_enter && !in_stop &&
        !stop_recovery_reset |=> in_stop)
        else $error("stop request not taken");
    a_pulse_exit: assert property (stop_recovery_reset |->
        !in_stop && $past(in_stop))
        else $error("recovery pulse outside stop exit");
    a_line_core: assert property ((!drive_cfg.comp_route)[*2] |->
        port3_line4 == $past(port3_line4_data) &&
        port3_line7 == $past(port3_line7_data))
        else $error("port 3 lines not from core");
    a_line_comp: assert property ((drive_cfg.comp_route &&
        $stable(comparator_in))[*5] |->
        {port3_line7, port3_line4} == comparator_in)
        else $error("comparators not routed");
    a_reset_cfg: assert property ($rose(resetn) |->
        drive_cfg == PSRC_PORT_CFG_RST)
        else $error("drive config reset value wrong");

    // Main scenarios reached
    c_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_recover: cover property (stop_recovery_reset);
    c_route: cover property (drive_cfg.comp_route);
endmodule

bind psrc_top psrc_props #(.STOP_DELAY_CYCLES(STOP_DELAY_CYCLES)) u_psrc_props (
    .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .in_stop(in_stop), .stop_enter(stop_enter),
    .stop_recovery_reset(stop_recovery_reset), .core_tick(core_tick),
    .timer_clock(timer_clock), .comparator_in(comparator_in),
    .port3_line4_data(port3_line4_data), .port3_line7_data(port3_line7_data),
    .port3_line4(port3_line4), .port3_line7(port3_line7),
    .drive_cfg(drive_cfg)
);
`default_nettype wire

// [sim/tb.sv]
// Purpose: Self-checking bench for psrc_top over APB.
// Assumes: STOP_DELAY_CYCLES shortened to 4.
// Notes:   Pins driven directly by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import psrc_pkg::*;
    localparam int DLY = 4;
    logic clk, resetn, irq, stop_enter, in_stop, stop_recovery_reset;
    logic core_tick, timer_clock, port3_line4, port3_line7;
    logic port3_line4_data, port3_line7_data, err;
    logic [3:0] port3_in;
    logic [7:0] port2_in;
    logic [1:0] comparator_in;
    logic [31:0] rd;
    psrc_apb_req_s apb_req;
    psrc_apb_rsp_s apb_rsp;
    psrc_port_cfg_s drive_cfg;
    int err_total, cmp_count, n, n_off, t;
    int tick_exp[4] = '{16, 1, 32, 2};
    logic [7:0] p2i_t[8] = '{0, 0, 0, 0, 0, 8'h00, 8'h01, 8'h80};
    logic [7:0] p2w_t[8] = '{0, 0, 0, 0, 0, 8'h80, 8'hF0, 8'h00};

    psrc_top #(.STOP_DELAY_CYCLES(DLY)) u_psrc_top (
        .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .irq(irq), .stop_enter(stop_enter), .in_stop(in_stop),
        .stop_recovery_reset(stop_recovery_reset), .core_tick(core_tick),
        .timer_clock(timer_clock), .port3_in(port3_in),
        .port2_in(port2_in), .comparator_in(comparator_in),
        .port3_line4_data(port3_line4_data),
        .port3_line7_data(port3_line7_data), .port3_line4(port3_line4),
        .port3_line7(port3_line7), .drive_cfg(drive_cfg));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer, waits for pready
    task automatic apb(input logic wr, input logic [5:0] ix, input int wd);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, {ix, 2'b00}, wd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // Enter stop, then present the wake pattern and time the exit
    task automatic stop_run(input logic [7:0] c, p3i, p3w, p2i, p2w);
        port3_in <= p3i[3:0];
        port2_in <= p2i;
        apb(1'b1, PSRC_IDX_STOP_CTRL, c);
        repeat (4) @(posedge clk);
        stop_enter <= 1'b1;
        @(posedge clk);
        stop_enter <= 1'b0;
        repeat (3) @(posedge clk);
        chk("in_stop", in_stop, 1);
        port3_in <= p3w[3:0];
        port2_in <= p2w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (stop_recovery_reset !== 1'b1 && n < 60);
        chk("exit", n < 60, 1);
    endtask

    task automatic ticks();
        t = 0;
        repeat (4) @(posedge clk);
        repeat (32) begin
            @(posedge clk);
            t += core_tick;
        end
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        apb_req = '0;
        {resetn, stop_enter, port3_line4_data, port3_line7_data} = '0;
        {port3_in, port2_in, comparator_in} = '0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk("cfg_rst", drive_cfg, PSRC_PORT_CFG_RST);
        apb(1'b0, PSRC_IDX_PORT_CFG, 0);
        chk("cfg_rd", rd, 0);
        apb(1'b1, PSRC_IDX_STOP_CTRL, 32'hA0);
        apb(1'b0, PSRC_IDX_STOP_CTRL, 0);
        chk("flag_rd", rd, 0);
        chk("ok_idx", err, 0);
        apb(1'b1, 6'h05, 32'hFF);
        chk("bad_idx", err, 1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, PSRC_IDX_PORT_CFG, 1 << i);
            repeat (2) @(posedge clk);
            chk("cfg_bit", drive_cfg, 1 << i);
        end
        comparator_in <= 2'b10;
        apb(1'b1, PSRC_IDX_PORT_CFG, 1);
        repeat (6) @(posedge clk);
        chk("comp", {port3_line7, port3_line4}, 2'b10);
        {port3_line7_data, port3_line4_data} <= 2'b01;
        apb(1'b1, PSRC_IDX_PORT_CFG, 0);
        repeat (3) @(posedge clk);
        chk("core_io", {port3_line7, port3_line4}, 2'b01);
        // Clock division table
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, PSRC_IDX_STOP_CTRL, 32'h20 + i);
            ticks();
            chk("ticks", t, tick_exp[i]);
        end
        // Every wake source, level high, delay off
        apb(1'b1, PSRC_IDX_IRQ_MASK, 3);
        for (int s = 1; s < 8; s++) begin
            stop_run(8'h40 | (s << 2), 0, (s < 5) ? (1 << (s - 1)) : 0,
                     p2i_t[s], p2w_t[s]);
            if (s == 1) n_off = n;
            chk("irq", irq, 1);
            port3_in <= '0;
            port2_in <= p2i_t[s];
            apb(1'b0, PSRC_IDX_IRQ_STATUS, 0);
            chk("status", rd[PSRC_IRQ_RECOVERED], 1);
            apb(1'b0, PSRC_IDX_STOP_CTRL, 0);
            chk("flag", rd, 32'h80);
        end
        // Low level, delay on, contents kept
        stop_run(8'h26, 1, 0, 0, 0);
        chk("delay", n, n_off + DLY);
        ticks();
        chk("kept", t, 32);
        // Masked wake leaves irq low
        apb(1'b1, PSRC_IDX_IRQ_MASK, 0);
        stop_run(8'h44, 0, 1, 0, 0);
        chk("masked", irq, 0);
        // Source 000 never wakes
        apb(1'b1, PSRC_IDX_STOP_CTRL, 32'h40);
        stop_enter <= 1'b1;
        @(posedge clk);
        stop_enter <= 1'b0;
        repeat (40) @(posedge clk);
        chk("no_wake", in_stop, 1);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, PSRC_IDX_STOP_CTRL, 0);
        chk("flag_clr", rd, 0);
        chk("run", in_stop, 0);
        close_out();
    end
endmodule
`default_nettype wire
